// ==== core/tpc_pkg.sv ====
/*
  Constants, register map and state types for the 10 Mbps twisted-pair control block.
  Assumes a 200 MHz core clock and an analog front end that hands over decoded bits.
*/
// How it works
// R1 - Line carries Manchester data; link pulses go out whenever MII transmit is idle.
// R2 - Scrambler and descrambler stay inactive in 10 Mbps twisted-pair mode.
// R3 - Stripping mode hides the preamble; valid data starts with nibbles 5 then D.
// R4 - Stripping mode raises carrier sense together with SFD recognition.
// R5 - Pass-through mode delivers the preamble, raising data valid and carrier sense together.
// R6 - Loopback returns every transmitted nibble, preamble included, to the receive side.
// R7 - Carrier sense rises on valid preamble and falls on end-of-frame; in stripping mode the code raises it only at SFD recognition.
// R8 - Alignment option drops carrier sense together with data valid.
// R9 - One to four dribble bits still deliver a nibble, padded with ones.
// R10 - Five to seven dribble bits drop the second partial nibble.
// R11 - With integrity test on, transmit only while link pulses or data keep arriving.
// R12 - Integrity-test override lets transmit pass regardless of link pulses.
// R13 - Lost pulses declare link failure and restart auto-negotiation when enabled; the code skips the restart while the integrity-test override is set.
// R14 - Heartbeat off after reset; when enabled COL pulses 5-15 bit times after transmit.
// R15 - Transmission outlasting the jabber timer shuts off transmit and loopback.
// R16 - Jabber ends after the unjabber interval; a config bit disables jabber.
// R17 - Eight inverted link pulses or four inverted end markers flip receive polarity.
// R18 - No pulses or data for the receive time-out resets polarity to normal.
// R19 - No fiber port at 10 Mbps.
// R20 - Link-up shows in two status bits.
// R21 - Negotiation done, speed and duplex show in status bits.
// R22 - Jabber and unjabber durations are parameters.
package tpc_pkg;
  localparam int CLK_NS        = 5;
  localparam int BIT_NS        = 100;
  localparam int BIT_CYC       = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SQE_BT        = 10;
  localparam int SQE_CYC       = SQE_BT * BIT_CYC;
  localparam int CYC_PER_MS    = 1000000 / CLK_NS;
  localparam int RX_TO_MS      = 96;
  localparam int RX_TO_CYC     = RX_TO_MS * CYC_PER_MS;
  localparam int LINK_LOSS_MS  = 100;
  localparam int LINK_LOSS_CYC = LINK_LOSS_MS * CYC_PER_MS;
  localparam int JAB_MS        = 20;
  localparam int JAB_CYC       = JAB_MS * CYC_PER_MS;
  localparam int UNJAB_MS      = 500;
  localparam int UNJAB_CYC     = UNJAB_MS * CYC_PER_MS;
  localparam int PULSE_INV_N   = 8;
  localparam int EOF_INV_N     = 4;

  localparam logic [7:0]  CFG_OFS  = 8'h00;
  localparam logic [7:0]  STAT_OFS = 8'h04;
  localparam logic [31:0] CFG_RST  = 32'h0000_0002;
  localparam int CFG_LOOP = 0;
  localparam int CFG_ANEN = 1;
  localparam int CFG_PRE  = 5;
  localparam int CFG_CRSA = 7;
  localparam int CFG_SQE  = 9;
  localparam int CFG_JABD = 10;
  localparam int CFG_LITD = 14;
  localparam int ST_POL   = 0;
  localparam int ST_JAB   = 1;
  localparam int ST_LINK  = 2;
  localparam int ST_AND   = 7;
  localparam int ST_FDX   = 9;
  localparam int ST_LINK2 = 10;
  localparam int ST_SPD   = 14;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [3:0] SFD_LO      = 4'h5;
  localparam logic [3:0] SFD_HI      = 4'hD;

  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'b00,
    RX_HUNT  = 2'b01,
    RX_DATA  = 2'b10,
    RX_FLUSH = 2'b11
  } tpc_rx_st_t;
endpackage : tpc_pkg

// ==== core/tpc_rx_path.sv ====
/*
  Receive nibble path: preamble strip or pass, carrier sense, dribble handling.
  Assumes bits arrive LSB first, polarity corrected, with frames byte aligned.
*/
`timescale 1ns/100ps
module tpc_rx_path
  import tpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       bit_stb_i,
  input  wire logic       bit_i,
  input  wire logic       active_i,
  input  wire logic       pass_pre_i,
  input  wire logic       crs_align_i,
  output logic [3:0]      rxd_o,
  output logic            rx_dv_o,
  output logic            crs_o,
  output logic            nib_stb_o
);
  tpc_rx_st_t st;
  logic [3:0] shift;
  logic [3:0] prev;
  logic [3:0] held;
  logic       held_v;
  logic [2:0] bcnt;
  logic [3:0] next_nib;

  function automatic logic [3:0] pad_ones(input logic [3:0] s, input logic [1:0] k);
    logic [3:0] r;
    r = 4'hF;
    case (k)
      2'd1:    r = {3'h7, s[3]};
      2'd2:    r = {2'h3, s[3:2]};
      2'd3:    r = {1'b1, s[3:1]};
      default: r = 4'hF;
    endcase
    return r;
  endfunction : pad_ones

  assign next_nib = {bit_i, shift[3:1]};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st        <= RX_IDLE;
      shift     <= 4'h0;
      prev      <= 4'h0;
      held      <= 4'h0;
      held_v    <= 1'b0;
      bcnt      <= 3'h0;
      rxd_o     <= 4'h0;
      rx_dv_o   <= 1'b0;
      crs_o     <= 1'b0;
      nib_stb_o <= 1'b0;
    end
    else
    begin
      nib_stb_o <= 1'b0;
      case (st)
        RX_IDLE:
        begin
          bcnt   <= 3'h0;
          held_v <= 1'b0;
          prev   <= 4'h0;
          if (active_i)
            st <= pass_pre_i ? RX_DATA : RX_HUNT;
        end
        RX_HUNT:
        begin
          if (!active_i)
            st <= RX_IDLE;
          else if (bit_stb_i)
          begin
            shift <= next_nib;
            bcnt  <= bcnt + 3'h1;
            if (bcnt[1:0] == 2'h3)
            begin
              prev <= next_nib;
              if (next_nib == SFD_HI && prev == SFD_LO)
              begin
                st        <= RX_DATA;
                rxd_o     <= SFD_LO; // R3
                rx_dv_o   <= 1'b1;
                crs_o     <= 1'b1; // R4
                nib_stb_o <= 1'b1;
                held      <= next_nib;
                held_v    <= 1'b1;
              end
            end
          end
        end
        RX_DATA:
        begin
          if (!active_i)
          begin
            st <= RX_FLUSH;
            if (!crs_align_i)
              crs_o <= 1'b0; // R7
          end
          else if (bit_stb_i)
          begin
            shift <= next_nib;
            bcnt  <= bcnt + 3'h1;
            if (bcnt[1:0] == 2'h3)
            begin
              held   <= next_nib;
              held_v <= 1'b1;
              if (held_v)
              begin
                rxd_o     <= held;
                rx_dv_o   <= 1'b1; // R5
                crs_o     <= 1'b1; // R5
                nib_stb_o <= 1'b1;
              end
            end
          end
        end
        RX_FLUSH:
        begin
          if (held_v)
          begin
            rxd_o     <= held;
            nib_stb_o <= rx_dv_o;
            held      <= pad_ones(shift, bcnt[1:0]); // R9
            held_v    <= (bcnt[1:0] != 2'h0) && !bcnt[2]; // R10
            bcnt      <= 3'h0;
          end
          else
          begin
            st      <= RX_IDLE;
            rx_dv_o <= 1'b0;
            crs_o   <= 1'b0; // R8
          end
        end
        default: st <= RX_IDLE;
      endcase
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_sfd_first: assert property ($rose(rx_dv_o) && st == RX_DATA && !pass_pre_i && $past(st) == RX_HUNT
                                   |-> rxd_o == SFD_LO) // R3
    else $error("first stripped nibble is not the SFD low nibble");
  chk_crs_dv_rise: assert property ($rose(crs_o) |-> $rose(rx_dv_o)) // R4
    else $error("carrier sense rose apart from data valid");
endmodule : tpc_rx_path

// ==== core/tpc_polarity.sv ====
/*
  Receive polarity detector with idle time-out.
  Assumes pulse and end-marker inversion flags come from the raw line comparator.
*/
`timescale 1ns/100ps
module tpc_polarity
  import tpc_pkg::*;
#(
  parameter int RX_TO = RX_TO_CYC
)
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pulse_i,
  input  wire logic pulse_inv_i,
  input  wire logic eof_i,
  input  wire logic eof_inv_i,
  input  wire logic active_i,
  output logic      pol_inv_o
);
  logic [3:0]  pcnt;
  logic [2:0]  ecnt;
  logic [31:0] idle_cnt;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pcnt <= 4'h0;
      ecnt <= 3'h0;
    end
    else
    begin
      if (pulse_i)
        pcnt <= pulse_inv_i ? ((pcnt == 4'(PULSE_INV_N)) ? pcnt : pcnt + 4'h1) : 4'h0;
      if (eof_i)
        ecnt <= eof_inv_i ? ((ecnt == 3'(EOF_INV_N)) ? ecnt : ecnt + 3'h1) : 3'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      idle_cnt <= 32'h0;
    else if (pulse_i || active_i)
      idle_cnt <= 32'h0;
    else if (idle_cnt != 32'(RX_TO - 1))
      idle_cnt <= idle_cnt + 32'h1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pol_inv_o <= 1'b0;
    else if ((pulse_i && pulse_inv_i && pcnt == 4'(PULSE_INV_N - 1)) ||
             (eof_i && eof_inv_i && ecnt == 3'(EOF_INV_N - 1)))
      pol_inv_o <= 1'b1; // R17
    else if (idle_cnt == 32'(RX_TO - 2) && !pulse_i && !active_i)
      pol_inv_o <= 1'b0; // R18
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_pol_pulses: assert property (pulse_i && pulse_inv_i && pcnt == 4'(PULSE_INV_N - 1) |=> pol_inv_o) // R17
    else $error("eighth inverted link pulse did not flip polarity");
endmodule : tpc_polarity

// ==== core/tpc_top.sv ====
/*
  10 Mbps twisted-pair control: MII receive/transmit steering, link integrity,
  heartbeat, jabber, loopback and polarity, with an AXI4-Lite register slave.
  Assumes a front end that decodes Manchester bits and flags pulses and end markers.
*/
`timescale 1ns/100ps
module tpc_top
  import tpc_pkg::*;
#(
  parameter int RX_TO     = RX_TO_CYC,
  parameter int LINK_LOSS = LINK_LOSS_CYC,
  parameter int JAB       = JAB_CYC, // R22
  parameter int UNJAB     = UNJAB_CYC // R22
)
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        ln_bit_stb_i,
  input  wire logic        ln_bit_i,
  input  wire logic        ln_active_i,
  input  wire logic        ln_pulse_i,
  input  wire logic        ln_pulse_inv_i,
  input  wire logic        ln_eof_i,
  input  wire logic        ln_eof_inv_i,
  output logic             ln_tx_en_o,
  output logic [3:0]       ln_txd_o,
  output logic             ln_lp_en_o,
  output logic             scram_en_o,
  output logic             fiber_en_o,
  input  wire logic        mii_tx_en_i,
  input  wire logic [3:0]  mii_txd_i,
  output logic [3:0]       mii_rxd_o,
  output logic             mii_rx_dv_o,
  output logic             mii_rx_stb_o,
  output logic             mii_crs_o,
  output logic             mii_col_o,
  input  wire logic        an_done_i,
  input  wire logic        an_fdx_i,
  input  wire logic        an_spd_i,
  output logic             an_restart_o
);
  logic        rst_q1;
  logic        rst_n;
  logic [31:0] cfg;
  logic [31:0] stat;
  logic        aw_v;
  logic        w_v;
  logic [7:0]  aw_a;
  logic [31:0] w_d;
  logic [3:0]  w_s;
  logic        link_ok;
  logic [31:0] link_cnt;
  logic        jabber;
  logic [31:0] tx_cnt;
  logic [31:0] unjab_cnt;
  logic        tx_en_q;
  logic [7:0]  sqe_cnt;
  logic        pol_inv;
  logic        tx_permit;
  logic        loop_on;
  logic [3:0]  rp_rxd;
  logic        rp_dv;
  logic        rp_crs;
  logic        rp_stb;

  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    logic [1:0] r;
    r = 2'h2;
    if (a[7:2] == CFG_OFS[7:2])
      r = 2'h0;
    else if (a[7:2] == STAT_OFS[7:2])
      r = 2'h1;
    return r;
  endfunction : reg_sel

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // Write channel
  assign s_axi_awready_o = !aw_v && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_v && !s_axi_bvalid_o;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_v           <= 1'b0;
      w_v            <= 1'b0;
      aw_a           <= 8'h00;
      w_d            <= 32'h0;
      w_s            <= 4'h0;
      cfg            <= CFG_RST; // R14
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_v <= 1'b1;
        aw_a <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_v <= 1'b1;
        w_d <= s_axi_wdata_i;
        w_s <= s_axi_wstrb_i;
      end
      if (aw_v && w_v)
      begin
        aw_v           <= 1'b0;
        w_v            <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (reg_sel(aw_a) == 2'h2) ? RESP_DECERR : RESP_OKAY;
        if (reg_sel(aw_a) == 2'h0)
          for (int i = 0; i < 4; i++)
            if (w_s[i])
              cfg[i*8 +: 8] <= w_d[i*8 +: 8];
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  // Read channel
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_comb
  begin
    stat           = 32'h0;
    stat[ST_POL]   = pol_inv;
    stat[ST_JAB]   = jabber;
    stat[ST_LINK]  = link_ok; // R20
    stat[ST_LINK2] = link_ok; // R20
    stat[ST_AND]   = an_done_i; // R21
    stat[ST_FDX]   = an_fdx_i; // R21
    stat[ST_SPD]   = an_spd_i; // R21
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0;
      s_axi_rresp_o  <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= (reg_sel(s_axi_araddr_i) == 2'h2) ? RESP_DECERR : RESP_OKAY;
      case (reg_sel(s_axi_araddr_i))
        2'h0:    s_axi_rdata_o <= cfg;
        2'h1:    s_axi_rdata_o <= stat;
        default: s_axi_rdata_o <= 32'h0;
      endcase
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  // Link integrity and failure
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_ok      <= 1'b0;
      link_cnt     <= 32'h0;
      an_restart_o <= 1'b0;
    end
    else
    begin
      an_restart_o <= 1'b0;
      if (ln_pulse_i || ln_active_i)
      begin
        link_ok  <= 1'b1; // R11
        link_cnt <= 32'h0;
      end
      else if (link_ok && link_cnt == 32'(LINK_LOSS - 1))
      begin
        link_ok      <= 1'b0; // R11
        link_cnt     <= 32'h0;
        an_restart_o <= cfg[CFG_ANEN] && !cfg[CFG_LITD]; // R13
      end
      else if (link_ok)
        link_cnt <= link_cnt + 32'h1;
    end
  end

  assign tx_permit = cfg[CFG_LITD] || link_ok; // R12
  assign loop_on   = cfg[CFG_LOOP] && !jabber; // R15

  // Jabber watch
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jabber    <= 1'b0;
      tx_cnt    <= 32'h0;
      unjab_cnt <= 32'h0;
    end
    else
    begin
      tx_cnt    <= (mii_tx_en_i && !jabber) ? tx_cnt + 32'h1 : 32'h0;
      unjab_cnt <= (jabber && !mii_tx_en_i) ? unjab_cnt + 32'h1 : 32'h0;
      if (cfg[CFG_JABD])
        jabber <= 1'b0; // R16
      else if (mii_tx_en_i && !jabber && tx_cnt == 32'(JAB - 1))
        jabber <= 1'b1; // R15
      else if (jabber && !mii_tx_en_i && unjab_cnt == 32'(UNJAB - 1))
        jabber <= 1'b0; // R16
    end
  end

  // Line transmit, link pulses, fixed modes
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ln_tx_en_o <= 1'b0;
      ln_txd_o   <= 4'h0;
      ln_lp_en_o <= 1'b0;
      tx_en_q    <= 1'b0;
    end
    else
    begin
      ln_tx_en_o <= mii_tx_en_i && tx_permit && !jabber && !cfg[CFG_LOOP]; // R1
      ln_txd_o   <= mii_txd_i;
      ln_lp_en_o <= !mii_tx_en_i; // R1
      tx_en_q    <= mii_tx_en_i;
    end
  end

  assign scram_en_o = 1'b0; // R2
  assign fiber_en_o = 1'b0; // R19

  // Heartbeat and collision
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sqe_cnt   <= 8'h00;
      mii_col_o <= 1'b0;
    end
    else
    begin
      if (tx_en_q && !mii_tx_en_i && cfg[CFG_SQE])
        sqe_cnt <= 8'(SQE_CYC); // R14
      else if (sqe_cnt != 8'h00)
        sqe_cnt <= sqe_cnt - 8'h01;
      mii_col_o <= (cfg[CFG_SQE] && ((tx_en_q && !mii_tx_en_i) || sqe_cnt > 8'h01)) ||
                   (mii_tx_en_i && ln_active_i && !cfg[CFG_LOOP] && !an_fdx_i);
    end
  end

  tpc_polarity #(
    .RX_TO       (RX_TO)
  ) u_pol (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .pulse_i     (ln_pulse_i),
    .pulse_inv_i (ln_pulse_inv_i),
    .eof_i       (ln_eof_i),
    .eof_inv_i   (ln_eof_inv_i),
    .active_i    (ln_active_i),
    .pol_inv_o   (pol_inv)
  );

  tpc_rx_path u_rx (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .bit_stb_i   (ln_bit_stb_i),
    .bit_i       (ln_bit_i ^ pol_inv), // R17
    .active_i    (ln_active_i && !cfg[CFG_LOOP]),
    .pass_pre_i  (cfg[CFG_PRE]),
    .crs_align_i (cfg[CFG_CRSA]),
    .rxd_o       (rp_rxd),
    .rx_dv_o     (rp_dv),
    .crs_o       (rp_crs),
    .nib_stb_o   (rp_stb)
  );

  // MII receive side, loopback steering
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mii_rxd_o    <= 4'h0;
      mii_rx_dv_o  <= 1'b0;
      mii_rx_stb_o <= 1'b0;
      mii_crs_o    <= 1'b0;
    end
    else if (cfg[CFG_LOOP])
    begin
      mii_rxd_o    <= mii_txd_i; // R6
      mii_rx_dv_o  <= loop_on && mii_tx_en_i; // R6
      mii_rx_stb_o <= loop_on && mii_tx_en_i;
      mii_crs_o    <= loop_on && mii_tx_en_i;
    end
    else
    begin
      mii_rxd_o    <= rp_rxd;
      mii_rx_dv_o  <= rp_dv;
      mii_rx_stb_o <= rp_stb;
      mii_crs_o    <= rp_crs || (mii_tx_en_i && !an_fdx_i);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  chk_sqe_pulse: assert property (cfg[CFG_SQE] && tx_en_q && !mii_tx_en_i ##1 cfg[CFG_SQE][*8]
                                  |-> mii_col_o[*8]) // R14
    else $error("heartbeat collision pulse missing after transmit");
  chk_jab_block: assert property (jabber |=> !ln_tx_en_o) // R15
    else $error("line transmit active during jabber");
  chk_jab_set: assert property (mii_tx_en_i && !jabber && !cfg[CFG_JABD] && tx_cnt == 32'(JAB - 1)
                                |=> jabber ##1 !ln_tx_en_o && !(cfg[CFG_LOOP] && mii_rx_dv_o)) // R15
    else $error("jabber not entered after the jabber time");
  chk_link_block: assert property (!tx_permit |=> !ln_tx_en_o) // R11
    else $error("transmit passed without link");
  chk_link_over: assert property (cfg[CFG_LITD] && mii_tx_en_i && !jabber && !cfg[CFG_LOOP]
                                  |=> ln_tx_en_o) // R12
    else $error("override did not allow transmit");
  chk_an_restart: assert property ($fell(link_ok)
                                   |-> an_restart_o == ($past(cfg[CFG_ANEN]) && !$past(cfg[CFG_LITD]))) // R13
    else $error("negotiation restart wrong on link failure");
  chk_lp_idle: assert property (!mii_tx_en_i |=> ln_lp_en_o) // R1
    else $error("link pulses not enabled while idle");
  chk_line_data: assert property (mii_tx_en_i |=> ln_txd_o == $past(mii_txd_i)) // R1
    else $error("line nibble does not follow transmit nibble");
  chk_loop_data: assert property (cfg[CFG_LOOP] && !jabber && mii_tx_en_i
                                  |=> mii_rx_dv_o && mii_rxd_o == $past(mii_txd_i)) // R6
    else $error("loopback nibble not returned");
  chk_status_link: assert property (stat[ST_LINK] == link_ok && stat[ST_LINK2] == link_ok) // R20
    else $error("link status bits disagree with link state");
  chk_scram_off: assert property (!scram_en_o && !fiber_en_o) // R2
    else $error("scrambler or fiber enabled at 10 Mbps");
endmodule : tpc_top

// ==== verification/tpc_mac_model.sv ====
/*
  MAC-side model: drives MII transmit nibbles and collects received nibbles.
  Assumes the block's MII receive outputs and the shared core clock.
*/
`timescale 1ns/100ps
module tpc_mac_model
  import tpc_pkg::*;
(
  input  wire logic       clk_i,
  output logic            tx_en_o,
  output logic [3:0]      txd_o,
  input  wire logic [3:0] rxd_i,
  input  wire logic       dv_i,
  input  wire logic       stb_i,
  input  wire logic       crs_i
);
  logic [3:0] rxq[$];
  int         n_split = 0;
  logic       crs_first = 1'b0;
  initial
  begin
    tx_en_o = 1'b0;
    txd_o   = 4'h0;
  end
  // Collect nibbles, note carrier sense apart from data valid
  always @(negedge clk_i)
  begin
    if (stb_i && dv_i)
      rxq.push_back(rxd_i);
    if (crs_i !== dv_i)
      n_split++;
    if (crs_i && !dv_i && rxq.size() == 0)
      crs_first = 1'b1;
  end
  // Frame of n nibbles counting up from v
  task automatic send(input int n, input logic [3:0] v);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      tx_en_o <= 1'b1;
      txd_o   <= v + 4'(i);
    end
    @(posedge clk_i);
    tx_en_o <= 1'b0;
    txd_o   <= ~txd_o;
  endtask : send
endmodule : tpc_mac_model

// ==== verification/testbench.sv ====
/*
  Testbench: AXI4-Lite register tasks, line bit frames, MAC model traffic.
  Assumes the design parameters shortened for simulation.
*/
`timescale 1ns/100ps
module testbench
  import tpc_pkg::*;
;
  localparam int LL = 400;
  localparam int JB = 50;
  localparam int UJ = 80;
  localparam int TO = 200;
  logic        clk, rstn, awv, wv, bry, arv, rry, bstb, lbit, act, pls, plsi, eof, eofi, adn, afd, asp;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  rsp;
  wire         awr, wrd, bv, arr, rv, ltx, llp, scr, fib, mtx, rdv, rstb, crs, col, anr;
  wire [1:0]   br, rr;
  wire [31:0]  rdata;
  wire [3:0]   ltxd, mtxd, rxd;
  int          n_errors = 0, n_compared = 0, cyc = 0, col_n = 0, txhi = 0, anr_n = 0, c0;
  tpc_top #(.RX_TO(TO), .LINK_LOSS(LL), .JAB(JB), .UNJAB(UJ)) dut (
    .clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .ln_bit_stb_i(bstb), .ln_bit_i(lbit),
    .ln_active_i(act), .ln_pulse_i(pls), .ln_pulse_inv_i(plsi), .ln_eof_i(eof), .ln_eof_inv_i(eofi),
    .ln_tx_en_o(ltx), .ln_txd_o(ltxd), .ln_lp_en_o(llp), .scram_en_o(scr), .fiber_en_o(fib),
    .mii_tx_en_i(mtx), .mii_txd_i(mtxd), .mii_rxd_o(rxd), .mii_rx_dv_o(rdv), .mii_rx_stb_o(rstb),
    .mii_crs_o(crs), .mii_col_o(col), .an_done_i(adn), .an_fdx_i(afd), .an_spd_i(asp),
    .an_restart_o(anr));
  tpc_mac_model mac (.clk_i(clk), .tx_en_o(mtx), .txd_o(mtxd), .rxd_i(rxd), .dv_i(rdv),
    .stb_i(rstb), .crs_i(crs));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Event counters and hang limit
  always @(negedge clk)
  begin
    cyc   <= cyc + 1;
    col_n <= col_n + int'(col);
    txhi  <= txhi + int'(ltx);
    anr_n <= anr_n + int'(anr);
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da = 1'b0;
    logic dw = 1'b0;
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    while (!(da && dw))
    begin
      @(posedge clk);
      if (awr)
        da = 1'b1;
      if (wrd)
        dw = 1'b1;
      awv <= !da;
      wv  <= !dw;
    end
    while (bv !== 1'b1)
      @(posedge clk);
    rsp = br;
    bry <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1)
      @(posedge clk);
    rd  = rdata;
    rsp = rr;
    rry <= 1'b0;
  endtask : rdr
  task automatic bits(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      lbit <= v[i];
      bstb <= 1'b1;
      @(posedge clk);
      bstb <= 1'b0;
      lbit <= ~v[i];
      @(posedge clk);
    end
  endtask : bits
  // Preamble, SFD, then tail bits; ends with an end-of-frame marker
  task automatic frame(input logic [63:0] tail, input int n);
    mac.rxq.delete();
    mac.crs_first = 1'b0;
    mac.n_split = 0;
    @(posedge clk);
    act <= 1'b1;
    bits(64'hD555_5555_5555_5555, 64);
    bits(tail, n);
    @(posedge clk);
    act <= 1'b0;
    eof <= 1'b1;
    @(posedge clk);
    eof <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : frame
  task automatic pulse(input logic inv);
    @(posedge clk);
    pls  <= 1'b1;
    plsi <= inv;
    @(posedge clk);
    pls <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : pulse
  function automatic logic [31:0] pk();
    logic [31:0] r = '0;
    foreach (mac.rxq[i])
      r = {r[27:0], mac.rxq[i]};
    return r;
  endfunction : pk
  task automatic results();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial
  begin
    {awv, wv, bry, arv, rry, bstb, lbit, act, pls, plsi, eof, eofi, awa, ara, wd} = '0;
    {adn, afd, asp} = 3'b111;
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdr(CFG_OFS);
    chk("cfg", rd, CFG_RST);
    chk("scr_fib", {scr, fib}, 2'b00);
    chk("lp", llp, 1'b1);
    rdr(8'h40);
    chk("decerr", rsp, RESP_DECERR);
    rdr(STAT_OFS);
    chk("an", {rd[ST_AND], rd[ST_FDX], rd[ST_SPD]}, 3'b111);
    frame(64'h0A7, 8);
    chk("strip", pk(), 32'h5D7A);
    chk("crs_first", mac.crs_first, 1'b0);
    frame(64'h0A7, 10);
    chk("drib2", pk(), 32'h5D7AC);
    frame(64'h0A7, 14);
    chk("drib6", pk(), 32'h5D7A0);
    rdr(STAT_OFS);
    chk("link", {rd[ST_LINK], rd[ST_LINK2]}, 2'b11);
    wr(CFG_OFS, 32'h0000_00A2);
    chk("bresp", rsp, RESP_OKAY);
    frame(64'h0A7, 8);
    chk("pass", pk(), 32'h5555_5D7A);
    chk("pass_n", mac.rxq.size(), 18);
    chk("split", mac.n_split, 0);
    wr(CFG_OFS, 32'h0000_0003);
    mac.rxq.delete();
    mac.send(6, 4'h1);
    repeat (4) @(posedge clk);
    chk("loop", pk(), 32'h12_3456);
    wr(CFG_OFS, 32'h0000_0202);
    pulse(1'b0);
    c0 = col_n;
    rd = txhi;
    mac.send(4, 4'h0);
    repeat (SQE_CYC + 20) @(posedge clk);
    chk("col", col_n - c0, SQE_CYC);
    chk("tx", txhi - rd, 4);
    c0 = anr_n;
    repeat (LL) @(posedge clk);
    rdr(STAT_OFS);
    chk("down", {rd[ST_LINK], rd[ST_LINK2]}, 2'b00);
    chk("restart", anr_n - c0, 1);
    rd = txhi;
    mac.send(4, 4'h0);
    repeat (4) @(posedge clk);
    chk("blocked", txhi - rd, 0);
    wr(CFG_OFS, 32'h0000_4000);
    c0 = txhi;
    mac.send(JB + 20, 4'h0);
    chk("ovr", txhi - c0 > 0, 1'b1);
    chk("jab_cut", txhi - c0 < JB + 20, 1'b1);
    rdr(STAT_OFS);
    chk("jab", rd[ST_JAB], 1'b1);
    repeat (UJ + 10) @(posedge clk);
    rdr(STAT_OFS);
    chk("unjab", rd[ST_JAB], 1'b0);
    wr(CFG_OFS, 32'h0000_4400);
    mac.send(JB + 20, 4'h0);
    rdr(STAT_OFS);
    chk("jabd", rd[ST_JAB], 1'b0);
    repeat (8) pulse(1'b1);
    rdr(STAT_OFS);
    chk("pol", rd[ST_POL], 1'b1);
    repeat (TO + 20) @(posedge clk);
    rdr(STAT_OFS);
    chk("pol_to", rd[ST_POL], 1'b0);
    results();
  end
endmodule : testbench
